// >>> verilog/ctu_pkg.sv
// package: register map, field positions and types of the charge time unit
package ctu_pkg;

	// ==========================================================
	// register offsets (byte addresses on the bus)
	localparam logic [11:0] OFS_CONTROL = 12'h000;
	localparam logic [11:0] OFS_CURRENT = 12'h004;
	localparam logic [11:0] OFS_INT_STATUS = 12'h008;
	localparam logic [11:0] OFS_INT_MASK = 12'h00C;
	localparam logic [11:0] OFS_REF_LEVEL = 12'h010;

	// ==========================================================
	// control register field positions
	localparam int BIT_MODULE_ENABLE = 15;
	localparam int BIT_IDLE_STOP = 13;
	localparam int BIT_DELAY_GEN = 12;
	localparam int BIT_EDGE_GATE = 11;
	localparam int BIT_SEQUENCE = 10;
	localparam int BIT_DISCHARGE = 9;
	localparam int BIT_TRIGGER = 8;
	localparam int BIT_EDGE2_POL = 7;
	localparam int BIT_EDGE2_SRC_LO = 5;
	localparam int BIT_EDGE1_POL = 4;
	localparam int BIT_EDGE1_SRC_LO = 2;
	localparam int BIT_EDGE2_STATUS = 1;
	localparam int BIT_EDGE1_STATUS = 0;

	// current register field positions
	localparam int BIT_TRIM_LO = 10;
	localparam int BIT_RANGE_LO = 8;

	// writable bit masks; bit 14 of control and bits 7-0 of current read 0
	localparam logic [15:0] CONTROL_MASK = 16'hBFFF;
	localparam logic [15:0] CURRENT_MASK = 16'hFF00;

	// reset values
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] CURRENT_RESET = 16'h0000;
	localparam logic [3:0] REF_RESET = 4'h0;
	localparam logic [2:0] INT_RESET = 3'h0;

	// interrupt status bit positions
	localparam int INT_EDGE1 = 0;
	localparam int INT_EDGE2 = 1;
	localparam int INT_PULSE = 2;

	// ==========================================================
	// edge source encodings
	typedef enum logic [1:0] {
		CTU_SRC_TIMER   = 2'h0,
		CTU_SRC_COMPARE = 2'h1,
		CTU_SRC_PIN_B   = 2'h2,
		CTU_SRC_PIN_A   = 2'h3
	} ctu_src_t;

	// current range encodings
	typedef enum logic [1:0] {
		CTU_RNG_OFF  = 2'h0,
		CTU_RNG_X1   = 2'h1,
		CTU_RNG_X10  = 2'h2,
		CTU_RNG_X100 = 2'h3
	} ctu_range_t;

	// edge source inputs, all synchronous to the system clock
	typedef struct packed {
		logic timer;
		logic compare;
		logic pin_b;
		logic pin_a;
	} ctu_edge_in_t;

	// controls for the analog current source and comparator
	typedef struct packed {
		logic       source_on;
		logic [1:0] range;
		logic [5:0] trim;
		logic       grounded;
		logic       to_comp_b;
		logic [3:0] ref_level;
	} ctu_analog_t;

endpackage : ctu_pkg

// >>> verilog/ctu_top.sv
// charge time unit: edge control, status, pulse and apb register file
// Summary of operation
// - edge detection, pulses, trigger and current source run only while module enable bit 15 is set
// - idle stop bit 13 halts the unit during device idle
// - delay generation bit 12 enables edge delay pulse mode
// - delay mode: source to comparator b, charge on edge, pulse on trip
// - edge gate bit 11 clear blocks all edges
// - sequence bit 10 makes edge 2 wait for edge 1
// - discharge bit 9 grounds the current source output
// - trigger output driven only while trigger bit 8 is set
// - polarity bits 7 and 4: 1 rising, 0 falling
// - source fields: 11 pin a, 10 pin b, 01 compare, 00 timer
// - status bits 1 and 0 show edge 2 and edge 1 occurred
// - output pulse spans the time between edge 1 and edge 2
// - six bit signed trim in current bits 15-10
// - range bits 9-8: 100x, 10x, 1x, off
// - 4-bit reference level picks one of 16 trip points
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module ctu_top (
	input  wire logic                  clk_i,
	input  wire logic                  rstn_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [11:0]           paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire ctu_pkg::ctu_edge_in_t edges_i,
	input  wire logic                  idle_i,
	input  wire logic                  comp_trip_i,
	output ctu_pkg::ctu_analog_t       analog_o,
	output logic                       pulse_o,
	output logic                       trigger_o,
	output logic                       delayed_pulse_output_o,
	output logic                       irq_o
);

	// ==========================================================
	// registers
	logic [15:0]          control;
	logic [15:0]          current;
	logic [3:0]           ref_level;
	logic [2:0]           int_status;
	logic [2:0]           int_mask;
	ctu_pkg::ctu_edge_in_t edges_q;
	logic                 trip_q;
	logic                 charging;
	logic [2:0]           next_int_status;
	logic [2:0]           next_int_mask;

	// ==========================================================
	// edge selection and detection
	function automatic logic pick(input ctu_pkg::ctu_edge_in_t e, input logic [1:0] s);
		case (s)
			ctu_pkg::CTU_SRC_PIN_A:   pick = e.pin_a;
			ctu_pkg::CTU_SRC_PIN_B:   pick = e.pin_b;
			ctu_pkg::CTU_SRC_COMPARE: pick = e.compare;
			default:                  pick = e.timer;
		endcase
	endfunction : pick

	logic       running;
	logic [1:0] sel_now;
	logic [1:0] sel_old;
	logic [1:0] pol;
	logic [1:0] hit;
	logic       wr_ok;
	logic       rd_ok;
	logic       sel_ctl;
	logic       sel_cur;
	logic       sel_int;
	logic       sel_msk;
	logic       sel_ref;

	assign running = control[ctu_pkg::BIT_MODULE_ENABLE]
		&& !(control[ctu_pkg::BIT_IDLE_STOP] && idle_i);
	assign pol[0] = control[ctu_pkg::BIT_EDGE1_POL];
	assign pol[1] = control[ctu_pkg::BIT_EDGE2_POL];

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_edge
			localparam int LO = (g == 0) ? ctu_pkg::BIT_EDGE1_SRC_LO : ctu_pkg::BIT_EDGE2_SRC_LO;
			assign sel_now[g] = pick(edges_i, control[LO+1:LO]);
			assign sel_old[g] = pick(edges_q, control[LO+1:LO]);
			// rising when polarity 1, falling when 0
			assign hit[g] = pol[g] ? (sel_now[g] && !sel_old[g])
				: (!sel_now[g] && sel_old[g]);
		end
	endgenerate

	logic edge1_ev;
	logic edge2_ev;
	assign edge1_ev = running && control[ctu_pkg::BIT_EDGE_GATE] && hit[0];
	assign edge2_ev = running && control[ctu_pkg::BIT_EDGE_GATE] && hit[1]
		&& (!control[ctu_pkg::BIT_SEQUENCE] || control[ctu_pkg::BIT_EDGE1_STATUS]
			|| edge1_ev);

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			edges_q <= '0;
			trip_q  <= 1'b0;
		end else begin
			edges_q <= edges_i;
			trip_q  <= comp_trip_i;
		end
	end

	// ==========================================================
	// apb decode
	assign sel_ctl = paddr_i == ctu_pkg::OFS_CONTROL;
	assign sel_cur = paddr_i == ctu_pkg::OFS_CURRENT;
	assign sel_int = paddr_i == ctu_pkg::OFS_INT_STATUS;
	assign sel_msk = paddr_i == ctu_pkg::OFS_INT_MASK;
	assign sel_ref = paddr_i == ctu_pkg::OFS_REF_LEVEL;
	assign wr_ok = psel_i && penable_i && pwrite_i;
	assign rd_ok = psel_i && penable_i && !pwrite_i;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i
		&& !(sel_ctl || sel_cur || sel_int || sel_msk || sel_ref);

	// register word as seen on the bus; upper half and unmapped words read 0
	function automatic logic [31:0] read_word(
		input logic [11:0] a,
		input logic [15:0] ctl,
		input logic [15:0] cur,
		input logic [2:0]  sts,
		input logic [2:0]  msk,
		input logic [3:0]  lvl
	);
		read_word = 32'h0000_0000;
		case (a)
			ctu_pkg::OFS_CONTROL:    read_word[15:0] = ctl;
			ctu_pkg::OFS_CURRENT:    read_word[15:0] = cur;
			ctu_pkg::OFS_INT_STATUS: read_word[2:0]  = sts;
			ctu_pkg::OFS_INT_MASK:   read_word[2:0]  = msk;
			ctu_pkg::OFS_REF_LEVEL:  read_word[3:0]  = lvl;
			default:                 read_word       = 32'h0000_0000;
		endcase
	endfunction : read_word

	// ==========================================================
	// control register with hardware-set status bits
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			control <= ctu_pkg::CONTROL_RESET;
		end else begin
			if (wr_ok && sel_ctl) begin
				control <= pwdata_i[15:0] & ctu_pkg::CONTROL_MASK;
			end
			// status set wins over a software write of 0
			if (edge1_ev) begin
				control[ctu_pkg::BIT_EDGE1_STATUS] <= 1'b1;
			end
			if (edge2_ev) begin
				control[ctu_pkg::BIT_EDGE2_STATUS] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			current   <= ctu_pkg::CURRENT_RESET;
			ref_level <= ctu_pkg::REF_RESET;
		end else begin
			if (wr_ok && sel_cur) begin
				current <= pwdata_i[15:0] & ctu_pkg::CURRENT_MASK;
			end
			if (wr_ok && sel_ref) begin
				ref_level <= pwdata_i[3:0];
			end
		end
	end

	// ==========================================================
	// measurement pulse: opens on edge 1, closes on edge 2
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pulse_o <= 1'b0;
		end else if (!running || control[ctu_pkg::BIT_DELAY_GEN]) begin
			pulse_o <= 1'b0;
		end else if (edge2_ev) begin
			pulse_o <= 1'b0;
		end else if (edge1_ev) begin
			pulse_o <= 1'b1;
		end
	end

	// ==========================================================
	// delay generation: charge from edge 1 until comparator trips
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			charging               <= 1'b0;
			delayed_pulse_output_o <= 1'b0;
		end else if (!running || !control[ctu_pkg::BIT_DELAY_GEN]) begin
			charging               <= 1'b0;
			delayed_pulse_output_o <= 1'b0;
		end else begin
			if (edge1_ev) begin
				charging               <= 1'b1;
				delayed_pulse_output_o <= 1'b0;
			end else if (charging && trip_q) begin
				charging               <= 1'b0;
				delayed_pulse_output_o <= 1'b1;
			end
		end
	end

	// trigger follows the measurement pulse, or the charging phase in delay mode
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			trigger_o <= 1'b0;
		end else begin
			trigger_o <= control[ctu_pkg::BIT_TRIGGER] && running
				&& (control[ctu_pkg::BIT_DELAY_GEN] ? (edge1_ev || charging)
					: (edge1_ev || pulse_o) && !edge2_ev);
		end
	end

	// ==========================================================
	// analog controls
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			analog_o <= '0;
		end else begin
			analog_o.range     <= current[ctu_pkg::BIT_RANGE_LO+1:ctu_pkg::BIT_RANGE_LO];
			analog_o.trim      <= current[ctu_pkg::BIT_TRIM_LO+5:ctu_pkg::BIT_TRIM_LO];
			analog_o.source_on <= running
				&& current[ctu_pkg::BIT_RANGE_LO+1:ctu_pkg::BIT_RANGE_LO] != ctu_pkg::CTU_RNG_OFF
				&& (control[ctu_pkg::BIT_DELAY_GEN] ? charging : pulse_o || edge1_ev);
			analog_o.grounded  <= control[ctu_pkg::BIT_DISCHARGE];
			analog_o.to_comp_b <= control[ctu_pkg::BIT_DELAY_GEN];
			analog_o.ref_level <= ref_level;
		end
	end

	// ==========================================================
	// interrupts: sticky, cleared by read, set wins
	logic [2:0] events;
	assign events = {(charging && trip_q), edge2_ev, edge1_ev};

	// a read clears only the bits it returned, so an event in the access cycle is kept
	always_comb begin
		next_int_status = int_status;
		if (rd_ok && sel_int) begin
			next_int_status = int_status & ~prdata_o[2:0];
		end
		next_int_status = next_int_status | events;
		next_int_mask = int_mask;
		if (wr_ok && sel_msk) begin
			next_int_mask = pwdata_i[2:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			int_status <= ctu_pkg::INT_RESET;
			int_mask   <= ctu_pkg::INT_RESET;
		end else begin
			int_status <= next_int_status;
			int_mask   <= next_int_mask;
		end
	end

	// level interrupt follows the status it will hold, with no extra cycle of lag
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(next_int_status & next_int_mask);
		end
	end

	// ==========================================================
	// read data: captured in the setup cycle, stands through the access phase
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_o <= read_word(paddr_i, control, current, int_status, int_mask, ref_level);
		end else begin
			prdata_o <= 32'h0000_0000;
		end
	end

endmodule : ctu_top

`default_nettype wire

// >>> tb/ctu_src_model.sv
// edge source model: timer, compare and two pin levels
`timescale 1ns/100ps
`default_nettype none
module ctu_src_model (
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic [3:0]       flip_i,
	output var ctu_pkg::ctu_edge_in_t edges_o
);
	// ==========================================================
	// each flip request toggles its source once, one edge per request
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			edges_o <= 4'h0;
		end else begin
			edges_o <= edges_o ^ flip_i;
		end
	end
endmodule : ctu_src_model
`default_nettype wire

// >>> tb/ctu_top_sva.sv
// checker: register shadow and edge control properties
`timescale 1ns/100ps
`default_nettype none
module ctu_top_sva (
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        idle_i,
	input wire logic        comp_trip_i,
	input wire ctu_pkg::ctu_analog_t analog_o,
	input wire logic        pulse_o,
	input wire logic        trigger_o,
	input wire logic        delayed_pulse_output_o
);
	logic        acc;
	logic [15:0] ctl;
	logic [15:0] cur;
	assign acc = psel_i && penable_i && pwrite_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// ==========================================================
	// shadow of the two configuration registers
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ctl <= 16'h0000;
			cur <= 16'h0000;
		end else if (acc && paddr_i == ctu_pkg::OFS_CONTROL) begin
			ctl <= pwdata_i[15:0] & ctu_pkg::CONTROL_MASK;
		end else if (acc && paddr_i == ctu_pkg::OFS_CURRENT) begin
			cur <= pwdata_i[15:0] & ctu_pkg::CURRENT_MASK;
		end
	end
	chk_cur_readback: assert property (psel_i && penable_i && !pwrite_i
		&& paddr_i == ctu_pkg::OFS_CURRENT |-> prdata_o == {16'h0000, cur}) else $error("bad current");
	chk_pulse_enable: assert property ($rose(pulse_o) |-> $past(ctl[15]) && $past(ctl[11]))
		else $error("pulse while off");
	chk_pulse_idle: assert property ($rose(pulse_o) |-> !($past(idle_i) && $past(ctl[13])))
		else $error("pulse in idle");
	chk_pulse_mode: assert property ($rose(pulse_o) |-> !$past(ctl[12]))
		else $error("pulse in delay mode");
	chk_trip_delay: assert property ($rose(delayed_pulse_output_o) |-> $past(comp_trip_i, 2)
		&& $past(ctl[12])) else $error("delayed pulse without trip");
	chk_ground_bit: assert property (analog_o.grounded |-> $past(ctl[9]))
		else $error("grounded while bit clear");
	chk_trigger_gate: assert property (trigger_o |-> $past(ctl[8]))
		else $error("trigger while disabled");
	chk_source_range: assert property (analog_o.source_on |-> $past(cur[9:8]) != 2'h0
		&& $past(ctl[15])) else $error("source on while off");
endmodule : ctu_top_sva
`default_nettype wire

// >>> tb/charge_time_edge_control_bench.sv
// bench: apb driver and scenarios for the charge time unit
`timescale 1ns/100ps
`default_nettype none
module charge_time_edge_control_bench;
	logic        clk_i, rstn_i, psel, penable, pwrite, comp_trip, idle;
	logic        pready, pslverr, er, trig, pulse, dpo, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, d;
	logic [3:0]  flip;
	logic [15:0] ctl_m;
	ctu_pkg::ctu_edge_in_t edges;
	ctu_pkg::ctu_analog_t  analog;
	int          miscompares, check_count, pw, tw, n;
	ctu_top u_ctu_top (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .edges_i(edges), .idle_i(idle),
		.comp_trip_i(comp_trip), .analog_o(analog), .pulse_o(pulse), .trigger_o(trig),
		.delayed_pulse_output_o(dpo), .irq_o(irq));
	ctu_src_model u_ctu_src_model (.clk_i(clk_i), .rstn_i(rstn_i), .flip_i(flip), .edges_o(edges));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (pulse === 1'b1) pw++;
		if (trig === 1'b1) tw++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
			miscompares++;
		end
	endtask : chk
	task automatic print_verdict();
		if (miscompares == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_i);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			miscompares++;
			print_verdict();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk_i);
		end
	endtask : apb
	// control word from the wanted sources; polarity picks the next transition
	task automatic cfg(input int s1, input int s2, input logic [15:0] x);
		ctl_m = x | 16'(!edges[3-s2]) << 7 | 16'(s2) << 5 | 16'(!edges[3-s1]) << 4 | 16'(s1) << 2;
		apb(1'b1, ctu_pkg::OFS_CONTROL, {16'h0000, ctl_m});
	endtask : cfg
	task automatic kick(input int s, input int gap);
		flip <= 4'h1 << (3 - s);
		@(posedge clk_i);
		flip <= 4'h0;
		repeat (gap - 1) @(posedge clk_i);
	endtask : kick
	task automatic blocked(input logic [15:0] x, input int s, input logic id);
		cfg(3, 2, x);
		idle <= id;
		kick(s, 4);
		idle <= 1'b0;
		apb(1'b0, ctu_pkg::OFS_CONTROL, 32'h0);
	endtask : blocked
	initial begin
		{psel, penable, pwrite, comp_trip, idle, flip, paddr, pwdata, rstn_i} = '0;
		void'($urandom(34));
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		for (int a = 0; a < 24; a += 4) begin
			apb(1'b0, 12'(a), 32'h0);
			chk(rd, 32'h0);
			chk(32'(er), 32'(a == 20));
		end
		for (int s = 0; s < 4; s++) begin
			int gap;
			gap = 2 + $urandom % 19;
			d = ($urandom & 32'hFFFFFCFF) | 32'(s) << 8;
			apb(1'b1, ctu_pkg::OFS_CURRENT, d);
			apb(1'b0, ctu_pkg::OFS_CURRENT, 32'h0);
			chk(rd, d & 32'h0000FF00);
			apb(1'b1, ctu_pkg::OFS_REF_LEVEL, d);
			apb(1'b0, ctu_pkg::OFS_REF_LEVEL, 32'h0);
			chk(rd, d & 32'h0000000F);
			apb(1'b1, ctu_pkg::OFS_INT_MASK, 32'(3 * (s % 2)));
			apb(1'b0, ctu_pkg::OFS_INT_MASK, 32'h0);
			chk(rd, 32'(3 * (s % 2)));
			cfg(s, (s + 1) % 4, 16'h8800 | 16'(s) << 8);
			pw = 0;
			tw = 0;
			kick(s, gap);
			kick((s + 1) % 4, 4);
			chk(pw, gap);
			chk(tw, (s % 2) * gap);
			chk(irq, s % 2);
			chk(32'(analog.grounded), 32'(s / 2));
			chk(32'(analog.range), 32'(s));
			chk(32'(analog.trim), 32'(d[15:10]));
			chk(32'(analog.ref_level), 32'(d[3:0]));
			chk(32'(analog.source_on), 32'h0);
			apb(1'b0, ctu_pkg::OFS_CONTROL, 32'h0);
			chk(rd, ctl_m | 16'h0003);
			apb(1'b0, ctu_pkg::OFS_INT_STATUS, 32'h0);
			chk(rd, 32'h3);
			@(posedge clk_i);
			chk(irq, 0);
			apb(1'b1, ctu_pkg::OFS_CONTROL, {16'h0000, ctl_m});
			apb(1'b0, ctu_pkg::OFS_CONTROL, 32'h0);
			chk(rd, ctl_m);
		end
		blocked(16'h8000, 3, 1'b0);
		chk(rd, ctl_m);
		blocked(16'h8C00, 2, 1'b0);
		chk(rd, ctl_m);
		blocked(16'hA800, 3, 1'b1);
		chk(rd, ctl_m);
		cfg(3, 2, 16'h9900);
		pw = 0;
		kick(3, 3);
		comp_trip <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (dpo !== 1'b1 && n < 10);
		chk(n, 3);
		chk(pw, 0);
		chk(32'(analog.to_comp_b), 32'h1);
		print_verdict();
	end
endmodule : charge_time_edge_control_bench
bind ctu_top ctu_top_sva u_sva (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .idle_i(idle_i), .comp_trip_i(comp_trip_i), .analog_o(analog_o),
	.pulse_o(pulse_o), .trigger_o(trigger_o), .delayed_pulse_output_o(delayed_pulse_output_o));
`default_nettype wire
